// File: pkg/fmrx_pkg.sv
// fault monitor constants and types
// assumes one system clock at 10 MHz, synchronous reset
package fmrx_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int RAM_AW = 8;
  localparam int RAM_DW = 8;
  localparam int SP_W = 16;
  localparam int NUM_SENS = 4;
  localparam int WDOG_W = 16;
  localparam int WDOG_TIME_US = 1000;
  localparam int WDOG_CYC = WDOG_TIME_US * (CLK_HZ / 1000000);
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  // reset cause bits
  localparam int RC_SENSOR = 0;
  localparam int RC_RAMPAR = 1;
  localparam int RC_ROMPAR = 2;
  localparam int RC_WDOG = 3;
  localparam int RC_W = 4;
  // exception cause bits
  localparam int EX_SENSOR = 0;
  localparam int EX_EECC = 1;
  localparam int EX_SP_USER = 2;
  localparam int EX_SP_SYS = 3;
  localparam int EX_SP_SUPER = 4;
  localparam int EX_W = 5;
  typedef enum logic [1:0] {FMRX_MODE_USER, FMRX_MODE_SYS, FMRX_MODE_SUPER} fmrx_mode_t;
  typedef enum logic [1:0] {FMRX_SCR_IDLE, FMRX_SCR_READ, FMRX_SCR_CHECK} fmrx_scr_t;
endpackage : fmrx_pkg

// File: pkg/fmrx_sp_if.sv
// stack pointer bundle between fault monitor and its stack limit checker
// assumes both ends on the system clock
`timescale 1ns/10ps
interface fmrx_sp_if;
  logic [fmrx_pkg::SP_W-1:0] sp;
  logic [fmrx_pkg::SP_W-1:0] lo;
  logic [fmrx_pkg::SP_W-1:0] hi;
  logic wr;
  logic [fmrx_pkg::SP_W-1:0] wdata;
  logic viol;
  modport owner (input sp, input viol, output lo, output hi, output wr, output wdata);
  modport checker_end (output sp, output viol, input lo, input hi, input wr, input wdata);
endinterface : fmrx_sp_if

// File: rtl/fmrx_sp_check.sv
// one stack pointer with its limit check
// assumes limits are written by the owner, lo <= hi
`timescale 1ns/10ps
module fmrx_sp_check (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  fmrx_sp_if.checker_end spi // pointer bundle
);
  typedef struct packed {
    logic [fmrx_pkg::SP_W-1:0] sp;
    logic viol;
  } fmrx_spc_t;
  fmrx_spc_t st_reg, st_next;
  always_comb
  begin
    st_next = st_reg;
    st_next.viol = 1'b0;
    if (spi.wr)
    begin
      st_next.sp = spi.wdata;
      // flag the move outside the window
      st_next.viol = (spi.wdata < spi.lo) || (spi.wdata > spi.hi);
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign spi.sp = st_reg.sp;
  assign spi.viol = st_reg.viol;
  property p_sp_viol;
    @(posedge clk) disable iff (rst)
    spi.wr && (spi.wdata > spi.hi) |=> spi.viol;
  endproperty
  a_sp_viol: assert property (p_sp_viol) else $error("sp over limit not flagged");
endmodule : fmrx_sp_check

// File: rtl/fmrx_monitor.sv
// fault monitor: sensors, memory checks, stack limits, watchdog, causes
// assumes memory/sensor inputs are on clk except sensor pins, which are async
// Operation
// - out-of-range sensor forces reset or exception
// - software switch for eeprom double read
// - inverted ecc option raises exception on error
// - ram parity checked on every read
// - random order scrubber on idle ram cycles
// - any ram parity error causes security reset
// - forced reset clears monitor state except stack pointers and limits, keeps readable cause; rst clears causes too
// - exception reason recorded for software
// - software cannot disable sensors or alarms
// - three stack pointers with own limits
// - stack beyond limits raises exception
// - high voltage result readable bit only
// - eeprom corrects single bit per byte
// - rom parity error forces reset
// - software enabled configurable flow watchdog
`timescale 1ns/10ps
module fmrx_monitor #(
  parameter int WDOG_DEFAULT = fmrx_pkg::WDOG_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, also any external reset
  input wire logic [fmrx_pkg::NUM_SENS-1:0] sens_alarm, // async sensor alarms
  input wire logic [fmrx_pkg::NUM_SENS-1:0] sens_is_reset, // strap: alarm class reset
  input wire logic dread_en_wr, // write strobe double read ctrl
  input wire logic dread_en_wdata, // value to write
  output logic dread_en, // double read enable
  input wire logic eecc_inv_opt, // inverse ecc option
  input wire logic ee_rd_valid, // eeprom byte read
  input wire logic [12:0] ee_rd_code, // 8 data + 5 check bits
  output logic [7:0] ee_rd_data, // corrected byte
  input wire logic ee_hv_sample, // write sequence hv sample strobe
  input wire logic ee_hv_ok, // hv sensor level
  output logic ee_hv_fail, // hv failed in last write
  input wire logic sw_ram_req, // software ram access
  input wire logic sw_ram_we, // software write
  input wire logic [fmrx_pkg::RAM_AW-1:0] sw_ram_addr, // address
  input wire logic [fmrx_pkg::RAM_DW-1:0] sw_ram_wdata, // write data
  output logic [fmrx_pkg::RAM_DW-1:0] sw_ram_rdata, // read data
  input wire logic rom_rd_valid, // rom word read
  input wire logic [8:0] rom_rd_word, // 8 data + parity
  input wire fmrx_pkg::fmrx_mode_t cpu_mode, // active mode
  input wire logic sp_wr, // push/pop new pointer
  input wire logic [fmrx_pkg::SP_W-1:0] sp_wdata, // new pointer value
  input wire logic lim_wr, // limit write strobe
  input wire fmrx_pkg::fmrx_mode_t lim_sel, // which pointer
  input wire logic [fmrx_pkg::SP_W-1:0] lim_lo, // low limit
  input wire logic [fmrx_pkg::SP_W-1:0] lim_hi, // high limit
  output logic [fmrx_pkg::SP_W-1:0] sp_out, // active pointer
  input wire logic wdog_cfg_wr, // watchdog config strobe
  input wire logic wdog_cfg_en, // enable
  input wire logic [fmrx_pkg::WDOG_W-1:0] wdog_cfg_load, // reload
  input wire logic wdog_kick, // program flow kick
  input wire logic rc_clr, // clear reset cause
  input wire logic ex_clr, // clear exception cause
  output logic [fmrx_pkg::RC_W-1:0] reset_cause, // sticky reset causes
  output logic [fmrx_pkg::EX_W-1:0] exc_cause, // sticky exception causes
  output logic sec_reset, // forced reset pulse
  output logic exc_req // exception pulse
);
  // elaboration check: the reload counter must hold the default
  if (WDOG_DEFAULT < 1 || WDOG_DEFAULT >= (1 << fmrx_pkg::WDOG_W))
  begin : g_bad_wdog
    $error("watchdog default out of range");
  end
  localparam logic [fmrx_pkg::WDOG_W-1:0] WDOG_INIT = WDOG_DEFAULT[fmrx_pkg::WDOG_W-1:0];
  localparam int NS = fmrx_pkg::NUM_SENS;
  localparam int DEPTH = 1 << fmrx_pkg::RAM_AW;

  function automatic logic [4:0] ecc_syn(input logic [12:0] c);
    logic [4:0] s;
    s[0] = c[0]^c[1]^c[3]^c[4]^c[6]^c[8];
    s[1] = c[0]^c[2]^c[3]^c[5]^c[6]^c[9];
    s[2] = c[1]^c[2]^c[3]^c[7]^c[10];
    s[3] = c[4]^c[5]^c[6]^c[7]^c[11];
    s[4] = ^c;
    return s;
  endfunction : ecc_syn

  function automatic logic [7:0] ecc_fix(input logic [12:0] c, input logic [4:0] s);
    logic [7:0] d;
    d = c[7:0];
    // even overall parity with a syndrome is a double error: leave the byte alone
    case (s[4] ? s[3:0] : 4'h0)
      4'h3: d[0] = ~d[0];
      4'h5: d[1] = ~d[1];
      4'h6: d[2] = ~d[2];
      4'h7: d[3] = ~d[3];
      4'h9: d[4] = ~d[4];
      4'ha: d[5] = ~d[5];
      4'hb: d[6] = ~d[6];
      4'hc: d[7] = ~d[7];
      default: d = c[7:0];
    endcase
    return d;
  endfunction : ecc_fix

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] sens;
    logic [NS-1:0] cls;
    logic cls_done;
    logic dread;
    logic [7:0] ee_data;
    logic hv_fail;
    logic [fmrx_pkg::RAM_DW-1:0] rdata;
    logic sw_rd_pend;
    logic [15:0] lfsr;
    fmrx_pkg::fmrx_scr_t scr;
    logic [fmrx_pkg::RAM_AW-1:0] scr_addr;
    logic wd_en;
    logic [fmrx_pkg::WDOG_W-1:0] wd_load;
    logic [fmrx_pkg::WDOG_W-1:0] wd_cnt;
    logic [fmrx_pkg::RC_W-1:0] rc;
    logic [fmrx_pkg::EX_W-1:0] ex;
    logic srst;
    logic exc;
  } fmrx_st_t;
  fmrx_st_t st_reg, st_next;

  logic [fmrx_pkg::RAM_DW:0] ram_mem [DEPTH];
  logic [fmrx_pkg::RAM_DW:0] ram_q;
  logic ram_rd;
  logic [fmrx_pkg::RAM_AW-1:0] ram_addr;

  fmrx_sp_if spu();
  fmrx_sp_if sps();
  fmrx_sp_if spx();
  fmrx_sp_check u_sp_user (.clk(clk), .rst(rst), .spi(spu));
  fmrx_sp_check u_sp_sys (.clk(clk), .rst(rst), .spi(sps));
  fmrx_sp_check u_sp_super (.clk(clk), .rst(rst), .spi(spx));

  logic [fmrx_pkg::SP_W-1:0] lo_q [3];
  logic [fmrx_pkg::SP_W-1:0] hi_q [3];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        lo_q[i] <= '0;
        hi_q[i] <= '1;
      end
    end
    else if (lim_wr)
    begin
      lo_q[lim_sel] <= lim_lo;
      hi_q[lim_sel] <= lim_hi;
    end
  end
  assign spu.lo = lo_q[0];
  assign spu.hi = hi_q[0];
  assign spu.wr = sp_wr && (cpu_mode == fmrx_pkg::FMRX_MODE_USER);
  assign spu.wdata = sp_wdata;
  assign sps.lo = lo_q[1];
  assign sps.hi = hi_q[1];
  assign sps.wr = sp_wr && (cpu_mode == fmrx_pkg::FMRX_MODE_SYS);
  assign sps.wdata = sp_wdata;
  assign spx.lo = lo_q[2];
  assign spx.hi = hi_q[2];
  assign spx.wr = sp_wr && (cpu_mode == fmrx_pkg::FMRX_MODE_SUPER);
  assign spx.wdata = sp_wdata;

  // ram with one parity bit per word; scrubber reads only on idle cycles
  assign ram_rd = (sw_ram_req && !sw_ram_we) || (!sw_ram_req && st_reg.scr == fmrx_pkg::FMRX_SCR_READ);
  assign ram_addr = sw_ram_req ? sw_ram_addr : st_reg.scr_addr;
  always_ff @(posedge clk)
  begin
    if (sw_ram_req && sw_ram_we)
      ram_mem[sw_ram_addr] <= {^sw_ram_wdata, sw_ram_wdata};
    if (ram_rd)
      ram_q <= ram_mem[ram_addr];
  end

  logic [4:0] syn;
  logic ee_err;
  logic ram_perr;
  logic rom_perr;
  logic wd_fire;
  logic [fmrx_pkg::RC_W-1:0] rc_ev;
  logic [fmrx_pkg::EX_W-1:0] ex_ev;
  logic [NS-1:0] sens_rise;

  always_comb
  begin
    st_next = st_reg;
    syn = ecc_syn(ee_rd_code);
    ee_err = ee_rd_valid && (syn != 5'h00);
    // three-stage sync, change taken when stages two and three agree
    st_next.s1 = sens_alarm;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < NS; i++)
      if (st_reg.s2[i] == st_reg.s3[i])
        st_next.sens[i] = st_reg.s3[i];
    sens_rise = st_next.sens & ~st_reg.sens;
    // class captured once after reset release; no software path to alarms
    if (!st_reg.cls_done)
    begin
      st_next.cls = sens_is_reset;
      st_next.cls_done = 1'b1;
    end
    if (dread_en_wr)
      st_next.dread = dread_en_wdata;
    if (ee_rd_valid)
      st_next.ee_data = ecc_fix(ee_rd_code, syn);
    if (ee_hv_sample)
      st_next.hv_fail = !ee_hv_ok;
    // scrubber walks lfsr addresses; a software access preempts it
    st_next.lfsr = st_reg.lfsr[0] ? ((st_reg.lfsr >> 1) ^ fmrx_pkg::LFSR_TAPS)
                                  : (st_reg.lfsr >> 1);
    st_next.sw_rd_pend = sw_ram_req && !sw_ram_we;
    ram_perr = 1'b0;
    case (st_reg.scr)
      fmrx_pkg::FMRX_SCR_IDLE:
      begin
        st_next.scr_addr = st_reg.lfsr[fmrx_pkg::RAM_AW-1:0];
        st_next.scr = fmrx_pkg::FMRX_SCR_READ;
      end
      fmrx_pkg::FMRX_SCR_READ:
      begin
        if (!sw_ram_req)
          st_next.scr = fmrx_pkg::FMRX_SCR_CHECK;
      end
      fmrx_pkg::FMRX_SCR_CHECK:
      begin
        ram_perr = ^ram_q;
        st_next.scr = fmrx_pkg::FMRX_SCR_IDLE;
      end
      default: st_next.scr = fmrx_pkg::FMRX_SCR_IDLE;
    endcase
    if (st_reg.sw_rd_pend)
    begin
      st_next.rdata = ram_q[fmrx_pkg::RAM_DW-1:0];
      ram_perr = ram_perr || (^ram_q);
    end
    rom_perr = rom_rd_valid && (^rom_rd_word);
    if (wdog_cfg_wr)
    begin
      st_next.wd_en = wdog_cfg_en;
      st_next.wd_load = wdog_cfg_load;
      st_next.wd_cnt = wdog_cfg_load;
    end
    else if (wdog_kick)
      st_next.wd_cnt = st_reg.wd_load;
    else if (st_reg.wd_en && st_reg.wd_cnt != '0)
      st_next.wd_cnt = st_reg.wd_cnt - 1'b1;
    wd_fire = st_reg.wd_en && st_reg.wd_cnt == '0 && !wdog_kick && !wdog_cfg_wr;
    rc_ev = '0;
    rc_ev[fmrx_pkg::RC_SENSOR] = |(sens_rise & st_reg.cls);
    rc_ev[fmrx_pkg::RC_RAMPAR] = ram_perr;
    rc_ev[fmrx_pkg::RC_ROMPAR] = rom_perr;
    rc_ev[fmrx_pkg::RC_WDOG] = wd_fire;
    ex_ev = '0;
    ex_ev[fmrx_pkg::EX_SENSOR] = |(sens_rise & ~st_reg.cls);
    ex_ev[fmrx_pkg::EX_EECC] = eecc_inv_opt && ee_err;
    ex_ev[fmrx_pkg::EX_SP_USER] = spu.viol;
    ex_ev[fmrx_pkg::EX_SP_SYS] = sps.viol;
    ex_ev[fmrx_pkg::EX_SP_SUPER] = spx.viol;
    // set wins over clear
    st_next.rc = (rc_clr ? '0 : st_reg.rc) | rc_ev;
    st_next.ex = (ex_clr ? '0 : st_reg.ex) | ex_ev;
    st_next.srst = |rc_ev;
    st_next.exc = (|ex_ev) && !(|rc_ev);
    if (st_reg.srst)
    begin
      // forced reset reinitialises st_reg except the cause indicators; stack pointers and limits keep their values
      st_next = '0;
      st_next.s1 = sens_alarm;
      st_next.lfsr = fmrx_pkg::LFSR_SEED;
      st_next.wd_load = WDOG_INIT;
      st_next.wd_cnt = WDOG_INIT;
      st_next.rc = st_reg.rc | rc_ev;
      st_next.ex = st_reg.ex | ex_ev;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.lfsr <= fmrx_pkg::LFSR_SEED;
      st_reg.wd_load <= WDOG_INIT;
      st_reg.wd_cnt <= WDOG_INIT;
    end
    else
      st_reg <= st_next;
  end

  logic [fmrx_pkg::SP_W-1:0] sp_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      sp_q <= '0;
    else
      case (cpu_mode)
        fmrx_pkg::FMRX_MODE_USER: sp_q <= spu.sp;
        fmrx_pkg::FMRX_MODE_SYS: sp_q <= sps.sp;
        default: sp_q <= spx.sp;
      endcase
  end
  assign sp_out = sp_q;
  assign dread_en = st_reg.dread;
  assign ee_rd_data = st_reg.ee_data;
  assign ee_hv_fail = st_reg.hv_fail;
  assign sw_ram_rdata = st_reg.rdata;
  assign reset_cause = st_reg.rc;
  assign exc_cause = st_reg.ex;
  assign sec_reset = st_reg.srst;
  assign exc_req = st_reg.exc;

  // the cycle in which sec_reset is high only records causes, it raises no new pulse
  property p_rom_reset;
    @(posedge clk) disable iff (rst)
    rom_rd_valid && (^rom_rd_word) && !sec_reset
      |=> sec_reset && reset_cause[fmrx_pkg::RC_ROMPAR];
  endproperty
  a_rom_reset: assert property (p_rom_reset) else $error("rom parity no reset");
  property p_prio;
    @(posedge clk) disable iff (rst)
    sec_reset |-> !exc_req;
  endproperty
  a_prio: assert property (p_prio) else $error("exception with reset");
  property p_eecc;
    @(posedge clk) disable iff (rst)
    eecc_inv_opt && ee_rd_valid && ecc_syn(ee_rd_code) != 5'h00 && !$past(sec_reset)
      |=> exc_cause[fmrx_pkg::EX_EECC];
  endproperty
  a_eecc: assert property (p_eecc) else $error("ecc exception lost");
  property p_hv;
    @(posedge clk) disable iff (rst)
    ee_hv_sample && !ee_hv_ok && !sec_reset |=> ee_hv_fail;
  endproperty
  a_hv: assert property (p_hv) else $error("hv fail not shown");
  property p_dread;
    @(posedge clk) disable iff (rst)
    dread_en_wr && !sec_reset |=> dread_en == $past(dread_en_wdata);
  endproperty
  a_dread: assert property (p_dread) else $error("double read ctrl");
  property p_sp_exc;
    @(posedge clk) disable iff (rst)
    spu.viol && !sec_reset |=> exc_cause[fmrx_pkg::EX_SP_USER];
  endproperty
  a_sp_exc: assert property (p_sp_exc) else $error("stack exception lost");
  property p_rc_sticky;
    @(posedge clk) disable iff (rst)
    reset_cause[fmrx_pkg::RC_RAMPAR] && !rc_clr |=> reset_cause[fmrx_pkg::RC_RAMPAR];
  endproperty
  a_rc_sticky: assert property (p_rc_sticky) else $error("cause lost");
  property p_wd;
    @(posedge clk) disable iff (rst)
    wd_fire && !sec_reset |=> sec_reset;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog no reset");
endmodule : fmrx_monitor

// File: tb/test_fault_monitor_reset_exception.sv
// self-checking bench for the fault monitor: memory-check table, then directed cases
// assumes the monitor alone; every port is driven here on the rising edge
`timescale 1ns/10ps
module test_fault_monitor_reset_exception;
  typedef struct packed {
    logic [12:0] code;
    logic inv;
    logic [8:0] rom;
    logic use_rom;
    logic [7:0] data;
    logic exc;
    logic sr;
  } fmrx_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sens_alarm = '0;
  logic [3:0] sens_is_reset = 4'h3; // strap: sensors 0,1 reset class, 2,3 exception class
  logic dread_en_wr = 1'b0;
  logic dread_en_wdata = 1'b0;
  logic eecc_inv_opt = 1'b0;
  logic ee_rd_valid = 1'b0;
  logic [12:0] ee_rd_code = '0;
  logic ee_hv_sample = 1'b0;
  logic ee_hv_ok = 1'b1;
  logic sw_ram_req = 1'b0;
  logic sw_ram_we = 1'b0;
  logic [fmrx_pkg::RAM_AW-1:0] sw_ram_addr = '0;
  logic [fmrx_pkg::RAM_DW-1:0] sw_ram_wdata = '0;
  logic rom_rd_valid = 1'b0;
  logic [8:0] rom_rd_word = '0;
  fmrx_pkg::fmrx_mode_t cpu_mode = fmrx_pkg::FMRX_MODE_USER;
  logic sp_wr = 1'b0;
  logic [fmrx_pkg::SP_W-1:0] sp_wdata = '0;
  logic lim_wr = 1'b0;
  fmrx_pkg::fmrx_mode_t lim_sel = fmrx_pkg::FMRX_MODE_USER;
  logic [fmrx_pkg::SP_W-1:0] lim_lo = '0;
  logic [fmrx_pkg::SP_W-1:0] lim_hi = '0;
  logic wdog_cfg_wr = 1'b0;
  logic wdog_cfg_en = 1'b0;
  logic [fmrx_pkg::WDOG_W-1:0] wdog_cfg_load = '0;
  logic wdog_kick = 1'b0;
  logic rc_clr = 1'b0;
  logic ex_clr = 1'b0;
  logic dread_en;
  logic [7:0] ee_rd_data;
  logic ee_hv_fail;
  logic [fmrx_pkg::RAM_DW-1:0] sw_ram_rdata;
  logic [fmrx_pkg::SP_W-1:0] sp_out;
  logic [fmrx_pkg::RC_W-1:0] reset_cause;
  logic [fmrx_pkg::EX_W-1:0] exc_cause;
  logic sec_reset;
  logic exc_req;
  int error_cnt = 0;
  int n_checks = 0;
  int sr_tot = 0;
  int ex_tot = 0;
  int s0;
  int e0;
  // zero codeword plus single flips, last row a double flip left uncorrected
  fmrx_row_t rows [9] = '{
    '{13'h0000, 1'b1, 9'h000, 1'b0, 8'h00, 1'b0, 1'b0},
    '{13'h0004, 1'b0, 9'h000, 1'b0, 8'h00, 1'b0, 1'b0},
    '{13'h0080, 1'b1, 9'h000, 1'b0, 8'h00, 1'b1, 1'b0},
    '{13'h0100, 1'b1, 9'h000, 1'b0, 8'h00, 1'b1, 1'b0},
    '{13'h1000, 1'b0, 9'h000, 1'b0, 8'h00, 1'b0, 1'b0},
    '{13'h0000, 1'b0, 9'h003, 1'b1, 8'h00, 1'b0, 1'b0},
    '{13'h0000, 1'b0, 9'h001, 1'b1, 8'h00, 1'b0, 1'b1},
    '{13'h0040, 1'b1, 9'h100, 1'b1, 8'h00, 1'b1, 1'b1},
    '{13'h0003, 1'b1, 9'h000, 1'b0, 8'h03, 1'b1, 1'b0}};

  fmrx_monitor #(.WDOG_DEFAULT(20)) dut_u (.clk(clk), .rst(rst), .sens_alarm(sens_alarm),
    .sens_is_reset(sens_is_reset), .dread_en_wr(dread_en_wr), .dread_en_wdata(dread_en_wdata),
    .dread_en(dread_en), .eecc_inv_opt(eecc_inv_opt), .ee_rd_valid(ee_rd_valid),
    .ee_rd_code(ee_rd_code), .ee_rd_data(ee_rd_data), .ee_hv_sample(ee_hv_sample),
    .ee_hv_ok(ee_hv_ok), .ee_hv_fail(ee_hv_fail), .sw_ram_req(sw_ram_req),
    .sw_ram_we(sw_ram_we), .sw_ram_addr(sw_ram_addr), .sw_ram_wdata(sw_ram_wdata),
    .sw_ram_rdata(sw_ram_rdata), .rom_rd_valid(rom_rd_valid), .rom_rd_word(rom_rd_word),
    .cpu_mode(cpu_mode), .sp_wr(sp_wr), .sp_wdata(sp_wdata), .lim_wr(lim_wr),
    .lim_sel(lim_sel), .lim_lo(lim_lo), .lim_hi(lim_hi), .sp_out(sp_out),
    .wdog_cfg_wr(wdog_cfg_wr), .wdog_cfg_en(wdog_cfg_en), .wdog_cfg_load(wdog_cfg_load),
    .wdog_kick(wdog_kick), .rc_clr(rc_clr), .ex_clr(ex_clr), .reset_cause(reset_cause),
    .exc_cause(exc_cause), .sec_reset(sec_reset), .exc_req(exc_req));

  always #50 clk = ~clk;

  // running totals of pulse cycles; tests compare deltas so pulse width counts too
  always @(posedge clk)
  begin
    sr_tot <= sr_tot + int'(sec_reset === 1'b1);
    ex_tot <= ex_tot + int'(exc_req === 1'b1);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic clr_causes();
    rc_clr <= 1'b1;
    ex_clr <= 1'b1;
    tick(1);
    rc_clr <= 1'b0;
    ex_clr <= 1'b0;
    tick(2);
  endtask : clr_causes

  task automatic dread_set(input logic v);
    dread_en_wdata <= v;
    dread_en_wr <= 1'b1;
    tick(1);
    dread_en_wr <= 1'b0;
    tick(2);
  endtask : dread_set

  task automatic sp_set(input logic [15:0] v);
    sp_wdata <= v;
    sp_wr <= 1'b1;
    tick(1);
    sp_wr <= 1'b0;
    tick(4);
  endtask : sp_set

  task automatic snap();
    s0 = sr_tot;
    e0 = ex_tot;
  endtask : snap

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("ERROR run expected end seen timeout");
    test_done();
  end

  initial
  begin
    fmrx_row_t r;
    tick(10);
    rst <= 1'b0;
    // whole ram written before the scrubber can leave its read state,
    // so it never meets unwritten parity
    sw_ram_req <= 1'b1;
    sw_ram_we <= 1'b1;
    for (int a = 0; a < 256; a++)
    begin
      sw_ram_addr <= 8'(a);
      sw_ram_wdata <= 8'(a) ^ 8'h5a;
      tick(1);
    end
    sw_ram_we <= 1'b0;
    sw_ram_req <= 1'b0;
    tick(2);
    $display("done: ram fill");
    foreach (rows[i])
    begin
      r = rows[i];
      eecc_inv_opt <= r.inv;
      tick(1);
      snap();
      ee_rd_code <= r.code;
      rom_rd_word <= r.rom;
      ee_rd_valid <= 1'b1;
      rom_rd_valid <= r.use_rom;
      tick(1);
      ee_rd_valid <= 1'b0;
      rom_rd_valid <= 1'b0;
      tick(6);
      check("ee_rd_data", ee_rd_data, r.data);
      check("exc_cause ecc", exc_cause[fmrx_pkg::EX_EECC], r.exc);
      check("reset_cause rom", reset_cause[fmrx_pkg::RC_ROMPAR], r.sr);
      check("sec_reset cycles", sr_tot - s0, r.sr);
      check("exc_req cycles", ex_tot - e0, r.exc & ~r.sr);
      clr_causes();
    end
    $display("done: memory check table");
    dread_set(1'b1);
    check("dread_en on", dread_en, 1'b1);
    dread_set(1'b0);
    check("dread_en off", dread_en, 1'b0);
    $display("done: double read control");
    // software switches thrown first must not mute the sensors
    wdog_cfg_en <= 1'b0;
    wdog_cfg_wr <= 1'b1;
    tick(1);
    wdog_cfg_wr <= 1'b0;
    snap();
    sens_alarm <= 4'h4;
    tick(8);
    sens_alarm <= 4'h0;
    tick(8);
    check("sensor exc seen", ex_tot != e0, 1'b1);
    check("exc_cause", exc_cause, 5'h01);
    check("sensor no reset", sr_tot - s0, 0);
    clr_causes();
    snap();
    sens_alarm <= 4'h1;
    tick(8);
    sens_alarm <= 4'h0;
    tick(10);
    check("sensor reset seen", sr_tot != s0, 1'b1);
    check("reset_cause", reset_cause, 4'h1);
    clr_causes();
    $display("done: sensors");
    for (int m = 0; m < 3; m++)
    begin
      lim_sel <= fmrx_pkg::fmrx_mode_t'(m);
      lim_lo <= 16'h0100;
      lim_hi <= 16'h01ff;
      lim_wr <= 1'b1;
      cpu_mode <= fmrx_pkg::fmrx_mode_t'(m);
      tick(1);
      lim_wr <= 1'b0;
      tick(1);
      snap();
      sp_set(16'h0100);
      sp_set(16'h01ff);
      check("sp in range", ex_tot - e0, 0);
      check("sp_out", sp_out, 16'h01ff);
      sp_set(16'h0200);
      check("sp over seen", ex_tot != e0, 1'b1);
      check("exc_cause sp", exc_cause, 32'h4 << m);
      clr_causes();
      snap();
      sp_set(16'h00ff);
      check("sp under seen", ex_tot != e0, 1'b1);
      sp_set(16'h0100 + 16'(m));
      clr_causes();
    end
    cpu_mode <= fmrx_pkg::FMRX_MODE_USER;
    tick(4);
    check("user sp kept", sp_out, 16'h0100);
    $display("done: stack limits");
    snap();
    ee_hv_ok <= 1'b0;
    ee_hv_sample <= 1'b1;
    tick(1);
    ee_hv_sample <= 1'b0;
    tick(4);
    check("ee_hv_fail", ee_hv_fail, 1'b1);
    check("hv no event", (sr_tot - s0) + (ex_tot - e0), 0);
    ee_hv_ok <= 1'b1;
    ee_hv_sample <= 1'b1;
    tick(1);
    ee_hv_sample <= 1'b0;
    tick(4);
    check("ee_hv_fail clear", ee_hv_fail, 1'b0);
    $display("done: high voltage");
    sw_ram_req <= 1'b1;
    snap();
    foreach (rows[i])
    begin
      sw_ram_addr <= 8'(i * 37);
      tick(1);
      sw_ram_req <= 1'b0;
      tick(3);
      check("sw_ram_rdata", sw_ram_rdata, 8'(i * 37) ^ 8'h5a);
      sw_ram_req <= 1'b1;
    end
    sw_ram_req <= 1'b0;
    tick(600);
    check("no parity reset", sr_tot - s0, 0);
    check("reset_cause ram", reset_cause, 4'h0);
    $display("done: ram");
    dread_set(1'b1);
    wdog_cfg_en <= 1'b1;
    wdog_cfg_load <= 16'h0014;
    wdog_cfg_wr <= 1'b1;
    tick(1);
    wdog_cfg_wr <= 1'b0;
    snap();
    repeat (6)
    begin
      tick(9);
      wdog_kick <= 1'b1;
      tick(1);
      wdog_kick <= 1'b0;
    end
    check("kicked no reset", sr_tot - s0, 0);
    tick(40);
    check("wdog reset", sr_tot - s0, 1);
    check("reset_cause wdog", reset_cause, 4'h8);
    check("dread_en reset", dread_en, 1'b0);
    $display("done: watchdog");
    dread_set(1'b1);
    eecc_inv_opt <= 1'b1;
    ee_rd_code <= 13'h0001;
    ee_rd_valid <= 1'b1;
    tick(1);
    ee_rd_valid <= 1'b0;
    tick(4);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    check("rst dread_en", dread_en, 1'b0);
    check("rst causes", {reset_cause, exc_cause}, 9'h000);
    check("rst sp_out", sp_out, 16'h0000);
    check("rst pulses", {sec_reset, exc_req, ee_hv_fail}, 3'h0);
    $display("done: mid-run reset");
    test_done();
  end
endmodule : test_fault_monitor_reset_exception
